// ### logic/ansr_node_regs.sv
// Purpose: Status and setting registers 2, 3 and 6 to 16 of one actuator node slot.
// Assumes: Requests arrive already decoded from the serial frame, one cycle wide.
// Notes: All actuator-side inputs come from logic on the same clock.
//
// Overview of operation
// - Low byte actuator flags, high byte gateway faults.
// - Low byte bit meanings; bits 4-7 fire only.
// - High byte bit meanings; 14 and 15 unused.
// - Compact actuators never set low byte flags.
// - Command code 4 clears low byte flags.
// - Bits 0 and 4 survive any clear.
// - High byte faults clear when condition ends.
// - Sensor type codes zero to four.
// - Sensor type zero makes input a local override.
// - Sensor reading follows configured sensor type.
// - Serial segments 1, 2, 4 in consecutive registers.
// - Actuator type codes zero to six.
// - Ten seconds silence drops node, type zero.
// - Countdown shows renewal seconds, reloads to 120.
// - Lower limit in hundredths, full scale 10000.
// - Upper limit in hundredths, full scale 10000.
// - Absolute flow valid for type 5, else 65535.
// - Expired fire override forces safety, flags error.
// - Command register returns to zero once forwarded.
// - Reads use function 3, writes function 6.
module ansr_node_regs
  import ansr_pkg::*;
#(
  parameter longint SECOND_COUNT = SECOND_CYCLES,
  parameter longint LOSS_COUNT = LOSS_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Master request and answer
  input wire logic req_valid_in,
  input wire ansr_req_type req_in,
  output logic rsp_valid_out,
  output ansr_rsp_type rsp_out,
  // Actuator reports and gateway fault conditions
  input wire logic report_valid_in,
  input wire ansr_report_type report_in,
  input wire logic checksum_fault_in,
  input wire logic node_error_fault_in,
  input wire logic unsupported_fault_in,
  input wire logic service_clear_in,
  // Actuator-side controls
  output logic cmd_valid_out,
  output logic [15:0] cmd_code_out,
  input wire logic cmd_ack_in,
  output logic [15:0] override_code_out,
  output logic safety_position_out,
  output logic local_override_out,
  output logic [15:0] sensor_kind_out,
  output logic [15:0] lower_limit_out,
  output logic [15:0] upper_limit_out
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ANSR_CMD_IDLE = 2'b01,
    ANSR_CMD_SEND = 2'b10
  } ansr_cmd_state_type;

  ansr_cmd_state_type cmd_state;
  logic [7:0] malfunction;
  logic [7:0] fault;
  logic [15:0] sensor_kind_select;
  logic [15:0] sensor_value;
  logic [15:0] serial_first;
  logic [15:0] serial_second;
  logic [15:0] serial_fourth;
  logic [15:0] node_kind;
  logic [15:0] flow_value;
  logic [15:0] countdown;
  logic [15:0] lower_limit;
  logic [15:0] upper_limit;
  logic [15:0] command;
  logic [31:0] second_count;
  logic [31:0] silence_count;
  logic node_lost;
  logic expired;

  // ---------------------------------------------------------------
  // Request decoding
  // ---------------------------------------------------------------
  function automatic logic is_write(input logic valid, input ansr_req_type req,
                                    input logic [15:0] addr);
    is_write = valid && (req.func == FUNC_WRITE_SINGLE) && (req.addr == addr);
  endfunction : is_write

  logic [7:0] next_exc;
  logic [15:0] next_data;
  logic wr_ok;
  logic wr_override;
  logic wr_command;
  logic is_fire;
  logic second_tick;
  logic [7:0] low_allowed;
  logic [7:0] low_clear;
  logic [15:0] error_word;
  logic [15:0] next_countdown;

  assign is_fire = (node_kind == KIND_FIRE_DAMPER);
  assign wr_ok = (next_exc == EXC_NONE);
  assign wr_override = is_write(req_valid_in, req_in, REG_OVERRIDE) && wr_ok;
  assign wr_command = is_write(req_valid_in, req_in, REG_COMMAND) && wr_ok;
  assign second_tick = (second_count == 32'(SECOND_COUNT - 1));
  assign error_word = {fault, malfunction};

  // Answer data and exception for the request being taken.
  always_comb begin
    next_exc = EXC_NONE;
    next_data = RESET_WORD;
    if (req_in.func == FUNC_READ_HOLDING) begin
      case (req_in.addr)
        REG_ERROR_MALFUNCTION_WORD: next_data = error_word;
        REG_SENSOR_KIND_SELECT: next_data = sensor_kind_select;
        REG_SENSOR_READING: next_data = sensor_value;
        REG_SERIAL_SEGMENT_FIRST: next_data = serial_first;
        REG_SERIAL_SEGMENT_SECOND: next_data = serial_second;
        REG_SERIAL_SEGMENT_FOURTH: next_data = serial_fourth;
        REG_NODE_KIND: next_data = node_kind;
        REG_OVERRIDE_RENEWAL_COUNTDOWN: next_data = countdown;
        REG_LOWER_LIMIT: next_data = lower_limit;
        REG_UPPER_LIMIT: next_data = upper_limit;
        REG_ABSOLUTE_FLOW: begin
          next_data = (node_kind == KIND_FLOW_CONTROLLER) ? flow_value : FLOW_INVALID;
        end
        default: next_exc = EXC_ILLEGAL_ADDRESS;
      endcase
    end else if (req_in.func == FUNC_WRITE_SINGLE) begin
      next_data = req_in.data;
      case (req_in.addr)
        REG_SENSOR_KIND_SELECT: begin
          if (req_in.data > SENSOR_MAX_CODE) begin
            next_exc = EXC_ILLEGAL_VALUE;
          end
        end
        REG_LOWER_LIMIT, REG_UPPER_LIMIT: begin
          if (req_in.data > LIMIT_FULL_SCALE) begin
            next_exc = EXC_ILLEGAL_VALUE;
          end
        end
        REG_OVERRIDE: begin
          if (req_in.data > OVERRIDE_FAST_CLOSED) begin
            next_exc = EXC_ILLEGAL_VALUE;
          end else if (is_fire && (req_in.data != OVERRIDE_OPEN)
                       && (req_in.data != OVERRIDE_FAST_CLOSED)) begin
            next_exc = EXC_ILLEGAL_VALUE;
          end
        end
        REG_COMMAND: begin
          if (req_in.data > CMD_MAX_CODE) begin
            next_exc = EXC_ILLEGAL_VALUE;
          end
        end
        default: next_exc = EXC_ILLEGAL_ADDRESS;
      endcase
    end else begin
      next_exc = EXC_ILLEGAL_FUNCTION;
    end
  end

  // ---------------------------------------------------------------
  // Answer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_out <= '0;
    end else begin
      rsp_valid_out <= req_valid_in;
      if (req_valid_in) begin
        rsp_out <= '{exc: next_exc, data: next_data};
      end
    end
  end

  // ---------------------------------------------------------------
  // Writable settings
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sensor_kind_select <= SENSOR_NONE;
      lower_limit <= RESET_WORD;
      upper_limit <= RESET_UPPER_LIMIT;
      override_code_out <= RESET_WORD;
    end else begin
      if (is_write(req_valid_in, req_in, REG_SENSOR_KIND_SELECT) && wr_ok) begin
        sensor_kind_select <= req_in.data;
      end
      if (is_write(req_valid_in, req_in, REG_LOWER_LIMIT) && wr_ok) begin
        lower_limit <= req_in.data;
      end
      if (is_write(req_valid_in, req_in, REG_UPPER_LIMIT) && wr_ok) begin
        upper_limit <= req_in.data;
      end
      if (wr_override) begin
        override_code_out <= req_in.data;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sensor_kind_out <= SENSOR_NONE;
      local_override_out <= 1'b1;
      lower_limit_out <= RESET_WORD;
      upper_limit_out <= RESET_UPPER_LIMIT;
    end else begin
      sensor_kind_out <= sensor_kind_select;
      local_override_out <= (sensor_kind_select == SENSOR_NONE);
      lower_limit_out <= lower_limit;
      upper_limit_out <= upper_limit;
    end
  end

  // ---------------------------------------------------------------
  // Command forwarding
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_state <= ANSR_CMD_IDLE;
      command <= CMD_NONE;
      cmd_valid_out <= 1'b0;
      cmd_code_out <= CMD_NONE;
    end else begin
      case (cmd_state)
        ANSR_CMD_IDLE: begin
          if (wr_command && (req_in.data != CMD_NONE)) begin
            command <= req_in.data;
            cmd_code_out <= req_in.data;
            cmd_valid_out <= 1'b1;
            cmd_state <= ANSR_CMD_SEND;
          end
        end
        ANSR_CMD_SEND: begin
          if (cmd_ack_in) begin
            command <= CMD_NONE;
            cmd_valid_out <= 1'b0;
            cmd_state <= ANSR_CMD_IDLE;
          end
        end
        default: begin
          cmd_state <= ANSR_CMD_IDLE;
          command <= CMD_NONE;
          cmd_valid_out <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Actuator reports and loss of communication
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      silence_count <= '0;
      node_lost <= 1'b0;
    end else if (report_valid_in) begin
      silence_count <= '0;
      node_lost <= 1'b0;
    end else if (silence_count == 32'(LOSS_COUNT - 1)) begin
      node_lost <= 1'b1;
    end else begin
      silence_count <= silence_count + 32'd1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      node_kind <= KIND_ABSENT;
      sensor_value <= RESET_WORD;
      serial_first <= RESET_WORD;
      serial_second <= RESET_WORD;
      serial_fourth <= RESET_WORD;
      flow_value <= FLOW_INVALID;
    end else if (report_valid_in) begin
      node_kind <= report_in.kind;
      sensor_value <= report_in.sensor;
      serial_first <= report_in.serial_first;
      serial_second <= report_in.serial_second;
      serial_fourth <= report_in.serial_fourth;
      flow_value <= report_in.flow;
    end else if (silence_count == 32'(LOSS_COUNT - 1)) begin
      node_kind <= KIND_ABSENT;
    end
  end

  // ---------------------------------------------------------------
  // Malfunction flags
  // ---------------------------------------------------------------
  always_comb begin
    low_allowed = LOW_GENERAL_MASK;
    if (report_in.kind == KIND_FIRE_DAMPER) begin
      low_allowed = LOW_GENERAL_MASK | LOW_FIRE_MASK;
    end
    if (report_in.kind == KIND_COMPACT) begin
      low_allowed = 8'h00;
    end
    low_clear = 8'h00;
    if ((wr_command && (req_in.data == CMD_CLEAR_MALFUNCTION)) || service_clear_in) begin
      low_clear = ~LOW_STICKY_MASK;
    end
  end

  // A report in the clearing cycle keeps its flags.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      malfunction <= 8'h00;
    end else begin
      malfunction <= (malfunction & ~low_clear)
                     | (report_valid_in ? (report_in.malfunction & low_allowed) : 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // Gateway faults, cleared as soon as their condition ends
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fault <= 8'h00;
    end else begin
      fault[BIT_NO_RESPONSE - 8] <= node_lost;
      fault[1] <= checksum_fault_in;
      fault[2] <= node_error_fault_in;
      fault[BIT_OUT_OF_RANGE - 8] <= req_valid_in && (next_exc == EXC_ILLEGAL_VALUE);
      fault[4] <= unsupported_fault_in;
      fault[BIT_TIME_EXCEEDED - 8] <= expired && is_fire;
      fault[7:6] <= 2'b00;
    end
  end

  // ---------------------------------------------------------------
  // Override renewal countdown
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      second_count <= '0;
    end else if (wr_override || second_tick) begin
      second_count <= '0;
    end else begin
      second_count <= second_count + 32'd1;
    end
  end

  always_comb begin
    next_countdown = countdown;
    if (wr_override) begin
      next_countdown = RENEWAL_S;
    end else if (!is_fire) begin
      next_countdown = RESET_WORD;
    end else if (second_tick && (countdown != RESET_WORD)) begin
      next_countdown = countdown - 16'd1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      countdown <= RESET_WORD;
      expired <= 1'b0;
      safety_position_out <= 1'b0;
    end else begin
      countdown <= next_countdown;
      if (wr_override || !is_fire) begin
        expired <= 1'b0;
        safety_position_out <= 1'b0;
      end else if (second_tick && (countdown == 16'd1)) begin
        expired <= 1'b1;
        safety_position_out <= 1'b1;
      end
    end
  end

endmodule : ansr_node_regs

// ### logic/ansr_pkg.sv
// Purpose: Shared constants and carriers of the node status register block.
// Assumes: One 20 MHz clock; register numbers are slot-relative (1 to 20).
// Notes: Long timing counts are overridable parameters of the top module.
package ansr_pkg;

  // ---------------------------------------------------------------
  // Register numbers within a node slot
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_OVERRIDE = 16'h0002;
  localparam logic [15:0] REG_COMMAND = 16'h0003;
  localparam logic [15:0] REG_ERROR_MALFUNCTION_WORD = 16'h0006;
  localparam logic [15:0] REG_SENSOR_KIND_SELECT = 16'h0007;
  localparam logic [15:0] REG_SENSOR_READING = 16'h0008;
  localparam logic [15:0] REG_SERIAL_SEGMENT_FIRST = 16'h0009;
  localparam logic [15:0] REG_SERIAL_SEGMENT_SECOND = 16'h000a;
  localparam logic [15:0] REG_SERIAL_SEGMENT_FOURTH = 16'h000b;
  localparam logic [15:0] REG_NODE_KIND = 16'h000c;
  localparam logic [15:0] REG_OVERRIDE_RENEWAL_COUNTDOWN = 16'h000d;
  localparam logic [15:0] REG_LOWER_LIMIT = 16'h000e;
  localparam logic [15:0] REG_UPPER_LIMIT = 16'h000f;
  localparam logic [15:0] REG_ABSOLUTE_FLOW = 16'h0010;

  // ---------------------------------------------------------------
  // Function codes and exception codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FUNC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  // ---------------------------------------------------------------
  // Field positions of the error word
  // ---------------------------------------------------------------
  localparam int BIT_EXCESS_UTIL = 0;
  localparam int BIT_SAFETY_FAULT = 4;
  localparam int BIT_NO_RESPONSE = 8;
  localparam int BIT_OUT_OF_RANGE = 11;
  localparam int BIT_TIME_EXCEEDED = 13;
  localparam logic [7:0] LOW_GENERAL_MASK = 8'h07;
  localparam logic [7:0] LOW_FIRE_MASK = 8'hf0;
  localparam logic [7:0] LOW_STICKY_MASK = 8'h11;

  // ---------------------------------------------------------------
  // Encodings and values
  // ---------------------------------------------------------------
  localparam logic [15:0] SENSOR_NONE = 16'h0000;
  localparam logic [15:0] SENSOR_MAX_CODE = 16'h0004;
  localparam logic [15:0] KIND_ABSENT = 16'h0000;
  localparam logic [15:0] KIND_FIRE_DAMPER = 16'h0004;
  localparam logic [15:0] KIND_FLOW_CONTROLLER = 16'h0005;
  localparam logic [15:0] KIND_COMPACT = 16'h0006;
  localparam logic [15:0] OVERRIDE_OPEN = 16'h0001;
  localparam logic [15:0] OVERRIDE_FAST_CLOSED = 16'h0006;
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_CLEAR_MALFUNCTION = 16'h0004;
  localparam logic [15:0] CMD_MAX_CODE = 16'h0004;
  localparam logic [15:0] LIMIT_FULL_SCALE = 16'h2710;
  localparam logic [15:0] FLOW_INVALID = 16'hffff;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] RESET_UPPER_LIMIT = 16'h2710;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint CLOCK_HZ = 20000000;
  localparam longint SECOND_CYCLES = CLOCK_HZ;
  localparam longint LOSS_TIMEOUT_S = 10;
  localparam longint LOSS_TIMEOUT_CYCLES = LOSS_TIMEOUT_S * CLOCK_HZ;
  localparam logic [15:0] RENEWAL_S = 16'd120;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] data;
  } ansr_req_type;

  typedef struct packed {
    logic [7:0] exc;
    logic [15:0] data;
  } ansr_rsp_type;

  typedef struct packed {
    logic [15:0] kind;
    logic [7:0] malfunction;
    logic [15:0] sensor;
    logic [15:0] serial_first;
    logic [15:0] serial_second;
    logic [15:0] serial_fourth;
    logic [15:0] flow;
  } ansr_report_type;

endpackage : ansr_pkg

// ### tb/ansr_actuator_model.sv
// Purpose: Actuator side model sending reports and taking commands.
// Assumes: Driven one nanosecond after each rising edge.
// Notes: Report contents are idle-inverted outside the report strobe.
module ansr_actuator_model
  import ansr_pkg::*;
(
  // Clock and report contents
  input wire logic core_clk_in,
  input wire logic run_in,
  input wire logic [15:0] kind_in,
  input wire logic [7:0] malf_in,
  input wire logic [15:0] flow_in,
  // Report and command hand-off
  output logic report_valid_out,
  output ansr_report_type report_out,
  input wire logic cmd_valid_in,
  output logic cmd_ack_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  logic run_seen;
  logic [2:0] wait_cnt;
  ansr_report_type rep;
  initial begin
    cnt = 4'h0;
    wait_cnt = 3'h0;
    report_valid_out = 1'b0;
    report_out = '0;
    cmd_ack_out = 1'b0;
  end
  always @(posedge core_clk_in) begin
    rep = {kind_in, malf_in, 16'h0321, 16'h0347, 16'h7a02, 16'h0008, flow_in};
    run_seen = run_in;
    #1;
    cnt = cnt + 4'h1;
    report_valid_out = run_seen && (cnt == 4'h0);
    report_out = report_valid_out ? rep : ~rep;
    wait_cnt = cmd_valid_in ? wait_cnt + 3'h1 : 3'h0;
    cmd_ack_out = (wait_cnt == 3'h3);
  end
endmodule : ansr_actuator_model

// ### tb/ansr_node_regs_checker.sv
// Purpose: Port-level checks of the node status register block.
// Assumes: One clock domain, reset active low.
// Notes: Attached to every instance by the bind at the foot.
module ansr_node_regs_checker
  import ansr_pkg::*;
#(
  parameter longint SECOND_COUNT = SECOND_CYCLES,
  parameter longint LOSS_COUNT = LOSS_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register access
  input wire logic req_valid_in,
  input wire ansr_req_type req_in,
  input wire logic rsp_valid_out,
  input wire ansr_rsp_type rsp_out,
  // Actuator side
  input wire logic cmd_valid_out,
  input wire logic [15:0] cmd_code_out,
  input wire logic cmd_ack_in,
  input wire logic safety_position_out,
  input wire logic local_override_out,
  input wire logic [15:0] lower_limit_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic rd;
  logic wr;
  assign rd = req_valid_in && (req_in.func == FUNC_READ_HOLDING);
  assign wr = req_valid_in && (req_in.func == FUNC_WRITE_SINGLE);
  rsp_timing_a: assert property (1'b1 |=> rsp_valid_out == $past(req_valid_in))
    else $error("Answer strobe misplaced.");
  bad_func_a: assert property (req_valid_in && !rd && !wr |=> rsp_out.exc == EXC_ILLEGAL_FUNCTION)
    else $error("Bad function not refused.");
  bad_addr_a: assert property (rd && (req_in.addr > REG_ABSOLUTE_FLOW)
    |=> rsp_out.exc == EXC_ILLEGAL_ADDRESS)
    else $error("Bad address not refused.");
  limit_refuse_a: assert property (wr && req_in.addr == REG_UPPER_LIMIT
    && req_in.data > LIMIT_FULL_SCALE |=> rsp_out.exc == EXC_ILLEGAL_VALUE)
    else $error("Oversize limit accepted.");
  lower_copy_a: assert property (wr && req_in.addr == REG_LOWER_LIMIT
    && req_in.data <= LIMIT_FULL_SCALE |-> ##2 lower_limit_out == $past(req_in.data, 2))
    else $error("Lower limit not applied.");
  cmd_start_a: assert property (wr && req_in.addr == REG_COMMAND && !cmd_valid_out
    && req_in.data == CMD_CLEAR_MALFUNCTION |=> cmd_valid_out && cmd_code_out == 16'h0004)
    else $error("Clear command not forwarded.");
  cmd_hold_a: assert property (cmd_valid_out && !cmd_ack_in
    |=> cmd_valid_out && $stable(cmd_code_out))
    else $error("Command dropped early.");
  cmd_done_a: assert property (cmd_valid_out && cmd_ack_in |=> !cmd_valid_out)
    else $error("Command not retired.");
  local_ovr_a: assert property (wr && req_in.addr == REG_SENSOR_KIND_SELECT
    && req_in.data == SENSOR_NONE |-> ##[1:2] local_override_out)
    else $error("Local override not set.");
  safety_clear_a: assert property (wr && req_in.addr == REG_OVERRIDE
    && req_in.data == OVERRIDE_FAST_CLOSED |-> ##2 !safety_position_out)
    else $error("Safety position kept.");
  cover property (cmd_valid_out && cmd_ack_in);
  cover property ($rose(safety_position_out));
  cover property (rd && req_in.addr == REG_ABSOLUTE_FLOW);
endmodule : ansr_node_regs_checker

bind ansr_node_regs ansr_node_regs_checker #(.SECOND_COUNT(SECOND_COUNT),
  .LOSS_COUNT(LOSS_COUNT)) u_ansr_node_regs_checker (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
  .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .cmd_valid_out(cmd_valid_out),
  .cmd_code_out(cmd_code_out), .cmd_ack_in(cmd_ack_in),
  .safety_position_out(safety_position_out), .local_override_out(local_override_out),
  .lower_limit_out(lower_limit_out));

// ### tb/tb_ansr_node_regs.sv
// Purpose: Self-checking bench of the node status register block.
// Assumes: Short second and silence counts set at the instance.
// Notes: The bench acts as master; the model acts as actuator.
module tb_ansr_node_regs
  import ansr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] WR = FUNC_WRITE_SINGLE;
  localparam logic [15:0] ERR = REG_ERROR_MALFUNCTION_WORD;
  logic core_clk_in, rst_n_in, req_valid_in, rsp_valid_out, report_valid_in;
  ansr_req_type req_in;
  ansr_rsp_type rsp_out, r;
  ansr_report_type report_in;
  logic checksum_fault_in, node_error_fault_in, unsupported_fault_in, service_clear_in;
  logic cmd_valid_out, cmd_ack_in, safety_position_out, local_override_out, run;
  logic [15:0] cmd_code_out, override_code_out, sensor_kind_out, lower_limit_out;
  logic [15:0] upper_limit_out, kind, flow;
  logic [7:0] malf;
  int fails, tests_run, cyc;
  ansr_node_regs #(.SECOND_COUNT(10), .LOSS_COUNT(50)) u_ansr_node_regs (.core_clk_in,
    .rst_n_in, .req_valid_in, .req_in, .rsp_valid_out, .rsp_out, .report_valid_in,
    .report_in, .checksum_fault_in, .node_error_fault_in, .unsupported_fault_in,
    .service_clear_in, .cmd_valid_out, .cmd_code_out, .cmd_ack_in, .override_code_out,
    .safety_position_out, .local_override_out, .sensor_kind_out, .lower_limit_out,
    .upper_limit_out);
  ansr_actuator_model u_ansr_actuator_model (.core_clk_in(core_clk_in), .run_in(run),
    .kind_in(kind), .malf_in(malf), .flow_in(flow), .report_valid_out(report_valid_in),
    .report_out(report_in), .cmd_valid_in(cmd_valid_out), .cmd_ack_out(cmd_ack_in));
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : ticks
  task automatic rq(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
    input logic [7:0] x);
    ticks(1);
    req_valid_in = 1'b1;
    req_in = {f, a, d};
    ticks(1);
    req_valid_in = 1'b0;
    chk({23'h000000, rsp_valid_out}, 24'h000001);
    r = rsp_out;
    chk({16'h0000, r.exc}, {16'h0000, x});
  endtask : rq
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rq(FUNC_READ_HOLDING, a, 16'h0000, EXC_NONE);
    chk({8'h00, r.data}, {8'h00, e});
  endtask : rd
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      end_sim();
    end
  end
  initial begin
    {core_clk_in, rst_n_in, req_valid_in, run, service_clear_in} = 5'h00;
    {checksum_fault_in, node_error_fault_in, unsupported_fault_in} = 3'h0;
    {req_in, kind, flow, malf} = '0;
    {fails, tests_run, cyc} = '0;
    ticks(2);
    rst_n_in = 1'b1;
    chk({23'h000000, local_override_out}, 24'h000001);
    rd(REG_SENSOR_KIND_SELECT, SENSOR_NONE);
    rd(REG_LOWER_LIMIT, RESET_WORD);
    rd(REG_UPPER_LIMIT, RESET_UPPER_LIMIT);
    rd(REG_ABSOLUTE_FLOW, FLOW_INVALID);
    rq(8'h10, REG_NODE_KIND, 16'h0000, EXC_ILLEGAL_FUNCTION);
    rq(FUNC_READ_HOLDING, 16'h0005, 16'h0000, EXC_ILLEGAL_ADDRESS);
    rq(FUNC_READ_HOLDING, 16'h0011, 16'h0000, EXC_ILLEGAL_ADDRESS);
    rq(WR, REG_SERIAL_SEGMENT_FIRST, 16'h1234, EXC_ILLEGAL_ADDRESS);
    rq(WR, REG_COMMAND, 16'h0005, EXC_ILLEGAL_VALUE);
    for (int i = 4; i >= 0; i--) begin
      rq(WR, REG_SENSOR_KIND_SELECT, 16'(i), EXC_NONE);
      rd(REG_SENSOR_KIND_SELECT, 16'(i));
      chk({8'h00, sensor_kind_out}, {8'h00, 16'(i)});
      chk({23'h000000, local_override_out}, {23'h000000, i == 0});
    end
    rq(WR, REG_SENSOR_KIND_SELECT, 16'h0005, EXC_ILLEGAL_VALUE);
    ticks(2);
    chk({23'h000000, local_override_out}, 24'h000001);
    rq(WR, REG_LOWER_LIMIT, LIMIT_FULL_SCALE, EXC_NONE);
    rd(REG_LOWER_LIMIT, LIMIT_FULL_SCALE);
    rq(WR, REG_UPPER_LIMIT, 16'h2711, EXC_ILLEGAL_VALUE);
    rd(REG_UPPER_LIMIT, RESET_UPPER_LIMIT);
    rq(WR, REG_UPPER_LIMIT, 16'h1388, EXC_NONE);
    ticks(2);
    chk({8'h00, upper_limit_out}, 24'h001388);
    {kind, malf, run} = {KIND_FIRE_DAMPER, 8'hff, 1'b1};
    ticks(20);
    malf = 8'h00;
    ticks(20);
    rd(ERR, 16'h00f7);
    rd(REG_SENSOR_READING, 16'h0321);
    rd(REG_SERIAL_SEGMENT_FIRST, 16'h0347);
    rd(REG_SERIAL_SEGMENT_SECOND, 16'h7a02);
    rd(REG_SERIAL_SEGMENT_FOURTH, 16'h0008);
    rd(REG_NODE_KIND, KIND_FIRE_DAMPER);
    rd(REG_ABSOLUTE_FLOW, FLOW_INVALID);
    rq(WR, REG_COMMAND, CMD_CLEAR_MALFUNCTION, EXC_NONE);
    chk({8'h00, cmd_code_out}, {8'h00, CMD_CLEAR_MALFUNCTION});
    ticks(8);
    chk({23'h000000, cmd_valid_out}, 24'h000000);
    rd(ERR, 16'h0011);
    malf = 8'h06;
    ticks(20);
    malf = 8'h00;
    rd(ERR, 16'h0017);
    service_clear_in = 1'b1;
    ticks(1);
    service_clear_in = 1'b0;
    rd(ERR, 16'h0011);
    {checksum_fault_in, node_error_fault_in, unsupported_fault_in} = 3'h7;
    ticks(2);
    rd(ERR, 16'h1611);
    {checksum_fault_in, node_error_fault_in, unsupported_fault_in} = 3'h0;
    ticks(2);
    rd(ERR, 16'h0011);
    rq(WR, REG_OVERRIDE, OVERRIDE_OPEN, EXC_NONE);
    rd(REG_OVERRIDE_RENEWAL_COUNTDOWN, RENEWAL_S);
    rq(WR, REG_OVERRIDE, 16'h0002, EXC_ILLEGAL_VALUE);
    ticks(1210);
    chk({23'h000000, safety_position_out}, 24'h000001);
    rd(ERR, 16'h2011);
    rq(WR, REG_OVERRIDE, OVERRIDE_FAST_CLOSED, EXC_NONE);
    ticks(2);
    chk({23'h000000, safety_position_out}, 24'h000000);
    chk({8'h00, override_code_out}, {8'h00, OVERRIDE_FAST_CLOSED});
    rd(REG_OVERRIDE_RENEWAL_COUNTDOWN, RENEWAL_S);
    run = 1'b0;
    ticks(60);
    rd(REG_NODE_KIND, KIND_ABSENT);
    rd(ERR, 16'h0111);
    {kind, flow, run} = {KIND_FLOW_CONTROLLER, 16'h04d2, 1'b1};
    ticks(20);
    rd(REG_ABSOLUTE_FLOW, 16'h04d2);
    rd(ERR, 16'h0011);
    {kind, malf} = {KIND_COMPACT, 8'hff};
    ticks(20);
    rd(ERR, 16'h0011);
    end_sim();
  end
endmodule : tb_ansr_node_regs
